// >>> core/serial_defs.vh
`ifndef SERIAL_DEFS_VH
`define SERIAL_DEFS_VH
`define CTRL1_OFFSET 4'h0
`define CTRL2_OFFSET 4'h4
`define STATUS_OFFSET 4'h8
`define RXBUF_OFFSET 4'hc
`define TXBUF_OFFSET 4'h0
`define TXBUF_ADDR 5'h10
`define C1_TXE 7
`define C1_RXE 6
`define C1_STOP 5
`define C1_EVEN 4
`define C1_PE 3
`define C1_RATE 0
`define C2_STOP 0
`define C2_FILT 1
`define C1_RESET 8'h00
`define C2_RESET 3'h0
`define RATE_BASE_DIV 13
`define RATE_FIXED_DIV 96
`define RATE_TIMER 3'h6
`define RATE_FIXED 3'h7
`define FILT_1 31
`define FILT_2 63
`define FILT_3 127
`endif

// >>> core/glitch_filter.v
`timescale 1ns/1ps
`include "serial_defs.vh"
module glitch_filter (
  input wire ref_clk,
  input wire rst_n,
  input wire [1:0] mode,
  input wire din,
  output reg dout
);
  reg [6:0] cnt_reg;
  reg [6:0] limit;
  always @* begin
    case (mode)
      2'h1: limit = 7'd`FILT_1;
      2'h2: limit = 7'd`FILT_2;
      default: limit = 7'd`FILT_3;
    endcase
  end
  // in modes 1 to 3 a new level must hold limit cycles before it passes; mode 0 passes it at once
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_reg <= 7'h00;
      dout <= 1'b1;
    end else if (mode == 2'h0) begin
      cnt_reg <= 7'h00;
      dout <= din;
    end else if (din == dout) begin
      cnt_reg <= 7'h00;
    end else if (cnt_reg >= limit - 7'h01) begin
      cnt_reg <= 7'h00;
      dout <= din;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end
endmodule

// >>> core/serial_txrx.v
`timescale 1ns/1ps
`include "serial_defs.vh"
module serial_txrx (
  input wire ref_clk,
  input wire rst_n,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire timer4_irq_clock,
  input wire rx_line,
  output reg tx_line,
  output reg tx_irq,
  output reg rx_irq
);
  localparam TX_IDLE = 2'h0;
  localparam TX_SHIFT = 2'h1;
  localparam RX_IDLE = 2'h0;
  localparam RX_BITS = 2'h1;
  localparam RX_WAIT = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] serial_ctrl_one;
  reg [2:0] serial_ctrl_two;
  reg [7:0] tx_holding_buf;
  reg [7:0] rx_holding_buf;
  reg tx_buf_empty_flag, tx_done_flag, rx_data_full_flag;
  reg parity_err_flag, frame_err_flag, overrun_flag;
  reg status_read_reg;
  reg aw_got_reg, w_got_reg;
  reg [4:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire tx_enable_bit = serial_ctrl_one[`C1_TXE];
  wire rx_enable_bit = serial_ctrl_one[`C1_RXE];
  wire tx_stop_len = serial_ctrl_one[`C1_STOP];
  wire even_sel = serial_ctrl_one[`C1_EVEN];
  wire parity_enable = serial_ctrl_one[`C1_PE];
  wire [2:0] rate_select = serial_ctrl_one[`C1_RATE +: 3];
  wire rx_stop_len = serial_ctrl_two[`C2_STOP];
  wire [1:0] rx_glitch_filter = serial_ctrl_two[`C2_FILT +: 2];
  wire [7:0] status_byte = {parity_err_flag, frame_err_flag, overrun_flag, rx_data_full_flag,
                            tx_done_flag, tx_buf_empty_flag, 2'b00};

  ////////////////////////////////////////////////////////////////////////
  // oversample tick generator, shared by both directions
  reg [12:0] div_cnt_reg;
  reg [12:0] div_max;
  reg tmr_d_reg;
  reg tick;
  always @* begin
    if (rate_select == `RATE_FIXED)
      div_max = 13'd`RATE_FIXED_DIV - 13'd1;
    else
      div_max = (13'd`RATE_BASE_DIV << rate_select) - 13'd1;
  end
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      div_cnt_reg <= 13'h0000;
      tmr_d_reg <= 1'b0;
      tick <= 1'b0;
    end else begin
      tmr_d_reg <= timer4_irq_clock;
      if (rate_select == `RATE_TIMER) begin
        div_cnt_reg <= 13'h0000;
        tick <= timer4_irq_clock & ~tmr_d_reg;
      end else if (div_cnt_reg >= div_max) begin
        div_cnt_reg <= 13'h0000;
        tick <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 13'h0001;
        tick <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  wire wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire wr_txbuf = wr_fire && aw_addr_reg[4:2] == 3'h4 && w_strb_reg[0];
  wire rd_status = rd_fire && s_axi_araddr[4:2] == 3'h2;
  wire rd_rxbuf = rd_fire && s_axi_araddr[4:2] == 3'h3;
  wire tx_accept = wr_txbuf && status_read_reg;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 5'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      serial_ctrl_one <= `C1_RESET;
      serial_ctrl_two <= `C2_RESET;
      tx_holding_buf <= 8'h00;
      status_read_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (aw_addr_reg == {1'b0, `CTRL1_OFFSET}) begin
          if (w_strb_reg[0])
            serial_ctrl_one <= w_data_reg[7:0];
        end else if (aw_addr_reg == {1'b0, `CTRL2_OFFSET}) begin
          if (w_strb_reg[0])
            serial_ctrl_two <= w_data_reg[2:0];
        end else if (aw_addr_reg == `TXBUF_ADDR) begin
          if (tx_accept)
            tx_holding_buf <= w_data_reg[7:0];
        end else if (aw_addr_reg == {1'b0, `STATUS_OFFSET} || aw_addr_reg == {1'b0, `RXBUF_OFFSET}) begin
          s_axi_bresp <= 2'h0;
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (s_axi_araddr == {1'b0, `CTRL1_OFFSET})
          s_axi_rdata <= {24'h000000, serial_ctrl_one};
        else if (s_axi_araddr == {1'b0, `CTRL2_OFFSET})
          s_axi_rdata <= {29'h00000000, serial_ctrl_two};
        else if (s_axi_araddr == {1'b0, `STATUS_OFFSET})
          s_axi_rdata <= {24'h000000, status_byte};
        else if (s_axi_araddr == {1'b0, `RXBUF_OFFSET})
          s_axi_rdata <= {24'h000000, rx_holding_buf};
        else if (s_axi_araddr == `TXBUF_ADDR)
          s_axi_rdata <= 32'h00000000;
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // status read arms one buffer access
      if (rd_status)
        status_read_reg <= 1'b1;
      else if (tx_accept || rd_rxbuf)
        status_read_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter
  reg [1:0] tx_state_reg;
  reg [3:0] tx_tick_reg;
  reg [3:0] tx_bit_reg;
  reg [10:0] tx_shift_reg;
  reg [3:0] tx_len_reg;
  reg tx_pending_reg;
  wire tx_par = ^tx_holding_buf ^ ~even_sel;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_state_reg <= TX_IDLE;
      tx_tick_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= 11'h7ff;
      tx_len_reg <= 4'h0;
      tx_pending_reg <= 1'b0;
      tx_buf_empty_flag <= 1'b1;
      tx_done_flag <= 1'b1;
      tx_line <= 1'b1;
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= 1'b0;
      if (tx_accept) begin
        tx_pending_reg <= 1'b1;
        tx_buf_empty_flag <= 1'b0;
      end
      case (tx_state_reg)
        TX_IDLE: begin
          tx_line <= 1'b1;
          if (tx_pending_reg && tx_enable_bit && tick) begin
            // frame: start, data lsb first, parity, stops
            if (parity_enable)
              tx_shift_reg <= {1'b1, tx_par, tx_holding_buf, 1'b0};
            else
              tx_shift_reg <= {2'b11, tx_holding_buf, 1'b0};
            tx_len_reg <= 4'd10 + {3'h0, parity_enable} + {3'h0, tx_stop_len};
            tx_bit_reg <= 4'h0;
            tx_tick_reg <= 4'h0;
            tx_pending_reg <= tx_accept;
            tx_buf_empty_flag <= ~tx_accept;
            tx_irq <= 1'b1;
            tx_done_flag <= 1'b0;
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          tx_line <= tx_shift_reg[0];
          if (tick) begin
            tx_tick_reg <= tx_tick_reg + 4'h1;
            if (tx_tick_reg == 4'hf) begin
              tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
              tx_bit_reg <= tx_bit_reg + 4'h1;
              if (tx_bit_reg == tx_len_reg - 4'h1) begin
                // disable takes hold only between frames
                tx_state_reg <= TX_IDLE;
                if (!tx_pending_reg && !tx_accept)
                  tx_done_flag <= 1'b1;
              end
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver
  wire rx_filt;
  glitch_filter u_filter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .mode(rx_glitch_filter),
    .din(rx_line),
    .dout(rx_filt)
  );
  reg [1:0] rx_state_reg;
  reg [3:0] rx_tick_reg;
  reg [3:0] rx_bit_reg;
  reg [3:0] rx_len_reg;
  reg [1:0] vote_reg;
  reg [9:0] rx_shift_reg;
  reg rx_bad_stop_reg;
  wire vote_bit = (vote_reg[1] & vote_reg[0]) | (vote_reg[1] & rx_filt) | (vote_reg[0] & rx_filt);
  reg ovr_seen_reg;
  // data sits one place higher when no parity bit was shifted in
  wire [7:0] rx_data = parity_enable ? rx_shift_reg[8:1] : rx_shift_reg[9:2];
  wire rx_par_bad = parity_enable && ((^rx_data) ^ rx_shift_reg[9] ^ ~even_sel);
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_state_reg <= RX_IDLE;
      rx_tick_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_len_reg <= 4'h0;
      vote_reg <= 2'h3;
      rx_shift_reg <= 10'h000;
      rx_bad_stop_reg <= 1'b0;
      ovr_seen_reg <= 1'b0;
      rx_holding_buf <= 8'h00;
      rx_data_full_flag <= 1'b0;
      parity_err_flag <= 1'b0;
      frame_err_flag <= 1'b0;
      overrun_flag <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= 1'b0;
      // read of buffer after status read clears flags
      if (rd_rxbuf && status_read_reg) begin
        rx_data_full_flag <= 1'b0;
        parity_err_flag <= 1'b0;
        frame_err_flag <= 1'b0;
        if (ovr_seen_reg)
          overrun_flag <= 1'b0;
      end
      // only an overrun shown by the status read may be cleared
      if (rd_status)
        ovr_seen_reg <= overrun_flag;
      case (rx_state_reg)
        RX_IDLE: begin
          // idle watch for a low level
          if (rx_enable_bit && !overrun_flag && tick && !rx_filt) begin
            rx_tick_reg <= 4'h1;
            rx_bit_reg <= 4'h0;
            rx_bad_stop_reg <= 1'b0;
            rx_len_reg <= 4'd10 + {3'h0, parity_enable} + {3'h0, rx_stop_len};
            rx_state_reg <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (tick) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == 4'h7)
              vote_reg[1] <= rx_filt;
            if (rx_tick_reg == 4'h8)
              vote_reg[0] <= rx_filt;
            if (rx_tick_reg == 4'h9) begin
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == 4'h0) begin
                if (vote_bit)
                  rx_state_reg <= RX_IDLE;
              end else if (rx_bit_reg <= 4'd8 + {3'h0, parity_enable}) begin
                rx_shift_reg <= {vote_bit, rx_shift_reg[9:1]};
              end else if (!vote_bit) begin
                rx_bad_stop_reg <= 1'b1;
              end
              if (rx_bit_reg == rx_len_reg - 4'h1)
                rx_state_reg <= RX_WAIT;
            end
          end
        end
        RX_WAIT: begin
          // deliver the frame
          rx_state_reg <= RX_IDLE;
          rx_irq <= 1'b1;
          // stop error is spent once the frame is delivered
          rx_bad_stop_reg <= 1'b0;
          if (rx_bad_stop_reg)
            frame_err_flag <= 1'b1;
          if (rx_data_full_flag && !(rd_rxbuf && status_read_reg)) begin
            overrun_flag <= 1'b1;
          end else begin
            rx_holding_buf <= rx_data;
            rx_data_full_flag <= 1'b1;
            if (rx_par_bad)
              parity_err_flag <= 1'b1;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end
endmodule

// >>> testbench/serial_checker_assertions.sv
`timescale 1ns/1ps
module serial_checker (
  input wire ref_clk,
  input wire rst_n,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire tx_line,
  input wire tx_irq,
  input wire rx_irq
);
  reg tx_wr;
  // remembers that the transmit buffer has been addressed since reset
  always @(posedge ref_clk) begin
    if (!rst_n)
      tx_wr <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 5'h10)
      tx_wr <= 1'b1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_tx_idle_high: assert property (!tx_wr |-> tx_line)
    else $error("tx line active before any buffer write");
  a_tx_irq_cause: assert property (tx_irq |-> tx_wr)
    else $error("transmit started without a buffer write");
  a_tx_irq_pulse: assert property (tx_irq |=> !tx_irq)
    else $error("tx irq longer than one cycle");
  a_tx_start_low: assert property (tx_irq |-> ##[0:3] !tx_line)
    else $error("no start bit after tx irq");
  a_start_bit_len: assert property ($fell(tx_line) |-> !tx_line [*8])
    else $error("start bit too short");
  a_rx_irq_pulse: assert property (rx_irq |=> !rx_irq)
    else $error("rx irq longer than one cycle");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  a_bad_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h10 |=> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  c_tx: cover property (tx_irq);
  c_rx: cover property (rx_irq);
  c_bad: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule
bind serial_txrx serial_checker u_serial_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_line(tx_line), .tx_irq(tx_irq), .rx_irq(rx_irq)
);

// >>> testbench/serial_peer.sv
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT_CYC = 208
) (
  input wire ref_clk,
  input wire tx_line,
  output reg rx_line
);
  reg [10:0] got = 11'h7ff;
  int count = 0;
  int bit_cyc = BIT_CYC;
  initial rx_line = 1'b1;
  // start low, data lsb first, parity after bit 7, stops high
  task send(input [7:0] v, input pe, input ev, input two, input bad_par, input bad_stop);
    reg [11:0] f;
    int n;
    begin
      n = 10 + pe + two;
      f = {2'b11, pe ? ((ev ? ^v : ~^v) ^ bad_par) : 1'b1, v, 1'b0};
      if (bad_stop)
        f[n - 1] = 1'b0;
      for (int k = 0; k < n; k++) begin
        rx_line <= f[k];
        repeat (bit_cyc) @(posedge ref_clk);
      end
      rx_line <= 1'b1;
      // idle guard so a low stop bit cannot run into the next start
      repeat (bit_cyc) @(posedge ref_clk);
    end
  endtask
  // captures eleven bits sampled mid-bit after each start edge
  initial begin
    forever begin
      @(posedge ref_clk);
      if (tx_line === 1'b0) begin
        repeat (bit_cyc / 2) @(posedge ref_clk);
        for (int k = 0; k < 11; k++) begin
          repeat (bit_cyc) @(posedge ref_clk);
          got[k] = tx_line;
        end
        count++;
      end
    end
  end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [4:0] awaddr = 5'h0;
  reg [4:0] araddr = 5'h0;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, tmr = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, rx_line, tx_line, tx_irq, rx_irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int num_errors = 0, compares = 0, cyc = 0, i, n;
  reg [31:0] rd;
  reg [1:0] rs;
  reg [7:0] d, d2;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tmr <= ~tmr;
  serial_txrx u_serial_txrx (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer4_irq_clock(tmr),
    .rx_line(rx_line), .tx_line(tx_line), .tx_irq(tx_irq), .rx_irq(rx_irq)
  );
  serial_peer u_serial_peer (.ref_clk(ref_clk), .tx_line(tx_line), .rx_line(rx_line));
  task close_out;
    begin
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      close_out;
    end
  end
  task check(input string what, input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // every handshake is judged with the values standing at the rising edge that takes it
  task axw(input [4:0] a, input [7:0] v);
    reg got;
    begin
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      got = 1'b0;
      while (!got) begin
        @(posedge ref_clk);
        got = bvalid === 1'b1;
        if (awvalid && awready === 1'b1)
          awvalid <= 1'b0;
        if (wvalid && wready === 1'b1)
          wvalid <= 1'b0;
      end
      bready <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // rready comes late so the slave must hold its answer for a cycle
  task axr(input [4:0] a);
    reg got;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      got = 1'b0;
      while (!got) begin
        @(posedge ref_clk);
        got = rready && (rvalid === 1'b1);
        if (got) begin
          rd = rdata;
          rs = rresp;
        end else if (!arvalid) begin
          rready <= 1'b1;
        end
        if (arvalid && arready === 1'b1)
          arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task wait_rx;
    begin
      @(negedge ref_clk);
      while (rx_irq !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
    end
  endtask
  function [10:0] tx_exp(input [7:0] v, input pe, input ev);
    tx_exp = {2'b11, pe ? (ev ? ^v : ~^v) : 1'b1, v};
  endfunction
  initial begin
    void'($urandom(96));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    axr(5'h08);
    check("status reset", rd, 32'h0c);
    axr(5'h14);
    check("bad addr", {30'h0, rs}, 32'h2);
    // every stop, parity and parity-sense combination in both directions
    for (i = 0; i < 8; i++) begin
      d = $urandom;
      d2 = $urandom;
      axw(5'h00, {2'b11, i[2], i[1], i[0], 3'h0});
      axw(5'h04, {5'h0, 2'($urandom % 3), i[2]});
      n = u_serial_peer.count;
      fork
        u_serial_peer.send(d2, i[0], i[1], i[2], 1'b0, 1'b0);
        wait_rx;
        begin
          axr(5'h08);
          axw(5'h10, d);
        end
      join
      while (u_serial_peer.count == n) @(posedge ref_clk);
      check("tx frame", u_serial_peer.got, tx_exp(d, i[0], i[1]));
      axr(5'h08);
      check("rx status", rd & 32'hf0, 32'h10);
      axr(5'h0c);
      check("rx data", rd, d2);
      axr(5'h08);
      check("rx clear", rd & 32'hf0, 32'h0);
      do
        axr(5'h08);
      while (!rd[3]);
    end
    // bad parity, bad single stop, bad second stop
    axw(5'h00, 8'hc8);
    for (i = 0; i < 3; i++) begin
      d = $urandom;
      axw(5'h04, {7'h0, i == 2});
      fork
        u_serial_peer.send(d, 1'b1, 1'b0, i == 2, i == 0, i > 0);
        wait_rx;
      join
      axr(5'h08);
      check("err status", rd & 32'hf0, i ? 32'h50 : 32'h90);
      axr(5'h0c);
      axr(5'h08);
      check("err clear", rd & 32'hf0, 32'h0);
    end
    d = $urandom;
    d2 = ~d;
    fork
      u_serial_peer.send(d, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      wait_rx;
    join
    fork
      u_serial_peer.send(d2, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      wait_rx;
    join
    axr(5'h08);
    check("ovr status", rd & 32'hf0, 32'h30);
    axr(5'h0c);
    check("ovr data", rd, d);
    axr(5'h08);
    check("ovr clear", rd & 32'hf0, 32'h0);
    axr(5'h0c);
    n = u_serial_peer.count;
    axw(5'h10, d);
    repeat (3000) @(posedge ref_clk);
    check("unarmed write", u_serial_peer.count, n);
    axr(5'h08);
    check("tx flags", rd & 32'h0c, 32'h0c);
    // a halved base-divider rate, then the timer-driven rate, both directions
    for (i = 0; i < 2; i++) begin
      d = $urandom;
      d2 = $urandom;
      axw(5'h00, 8'h00);
      axw(5'h04, 8'h00);
      axw(5'h00, i ? 8'hce : 8'hc1);
      u_serial_peer.bit_cyc = i ? 32 : 416;
      n = u_serial_peer.count;
      fork
        u_serial_peer.send(d2, i[0], 1'b0, 1'b0, 1'b0, 1'b0);
        wait_rx;
        begin
          axr(5'h08);
          axw(5'h10, d);
        end
      join
      while (u_serial_peer.count == n) @(posedge ref_clk);
      check("rate tx", u_serial_peer.got, tx_exp(d, i[0], 1'b0));
      axr(5'h08);
      axr(5'h0c);
      check("rate rx", rd, d2);
      do
        axr(5'h08);
      while (!rd[3]);
    end
    close_out;
  end
endmodule
